// ===== shared/i2c_master_consts.svh
/*
  Holds the address map, field positions, reset values and bus answer codes of the I2C master data and count
  registers. Assumes inclusion by bare name from the package, the checker and the testbench.
*/
`ifndef I2C_MASTER_CONSTS_SVH
`define I2C_MASTER_CONSTS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_RECEIVE_BYTE 32'hFFFF0888
`define ADDR_TRANSMIT_BYTE 32'hFFFF088C
`define ADDR_READ_LENGTH 32'hFFFF0890
`define ADDR_READ_PROGRESS 32'hFFFF0894
`define ADDR_TARGET_ADDRESS 32'hFFFF0898
`define ADDR_CLOCK_DIVIDER 32'hFFFF08A4
`define ADDR_MASTER_STATUS 32'hFFFF08A8

// ************************************************************
// Reset values
// ************************************************************
`define RST_BYTE 8'h00
`define RST_READ_LENGTH 9'h000
`define RST_CLOCK_DIVIDER 16'h1F1F

// ************************************************************
// Field positions
// ************************************************************
`define LEN_EXT_BIT 8
`define ADDR_DIR_BIT 0
`define DIV_HIGH_MSB 15
`define DIV_HIGH_LSB 8
`define DIV_LOW_MSB 7
`define DIV_LOW_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1

// ************************************************************
// Bit counting and bus answers
// ************************************************************
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== shared/i2c_master_pkg.sv
/*
  Holds the types of the I2C master: engine states and byte kinds.
  Assumes the constants header is on the include path.
*/
`default_nettype none
package i2c_master_pkg;
  `include "i2c_master_consts.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BIT_LOW = 3'b010,
    ST_BIT_HIGH = 3'b011,
    ST_STOP_LOW = 3'b100,
    ST_STOP_HIGH = 3'b101
  } engine_state_e;

  typedef enum logic [1:0] {
    KIND_ADDRESS = 2'b00,
    KIND_TRANSMIT = 2'b01,
    KIND_RECEIVE = 2'b10
  } byte_kind_e;
endpackage
`default_nettype wire

// ===== shared/scl_timing_if.sv
/*
  Carries the divider setting, run request, current clock half and phase tick between the engine and the
  serial clock timer. Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface scl_timing_if;
  logic [15:0] divValue;
  logic run;
  logic sclHigh;
  logic tick;

  modport engine (output divValue, output run, output sclHigh, input tick);
  modport timer (input divValue, input run, input sclHigh, output tick);
endinterface
`default_nettype wire

// ===== rtl/scl_timer.sv
/*
  Holds the serial clock phase timer: one tick at the end of each clock half, high half from the upper
  divider byte, low half from the lower. Assumes a single clock and synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none
module scl_timer
  import i2c_master_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  scl_timing_if.timer tim
);

  logic [7:0] count_q;
  logic [7:0] limit;
  logic tick_q;

  // ************************************************************
  // Half period length
  // ************************************************************
  always_comb begin
    if (tim.sclHigh) begin
      limit = tim.divValue[`DIV_HIGH_MSB:`DIV_HIGH_LSB];
    end else begin
      limit = tim.divValue[`DIV_LOW_MSB:`DIV_LOW_LSB];
    end
  end

  // ************************************************************
  // Counter and tick
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst || !tim.run || tick_q) begin
      count_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign tim.tick = tick_q;

endmodule // scl_timer
`default_nettype wire

// ===== rtl/i2c_master_data_count_regs.sv
/*
  Holds the I2C master data path: receive, transmit, read length, read progress, target address and clock
  divider registers on an Avalon-MM slave with waitrequest, plus a byte engine on open-drain SCL and SDA.
  Assumes a 100 MHz clock, synchronous reset, and external pull-ups resolving the open-drain wires.
*/
// Overview of operation
// - Software loads read length before starting reads
// - Length low byte is byte total minus one
// - Bit eight extends reads beyond 256 bytes
// - Eight-bit read-only count of received bytes
// - Clock divider resets to 0x1F1F
// - Address bits 7:1 target, bit 0 direction
// - Divider sets serial clock frequency
`timescale 1ns/1ns
`default_nettype none
module i2c_master_data_count_regs
  import i2c_master_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic [1:0] avsResponse,
  output logic avsWaitRequest,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] wr, input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wr[7:0];
    end
    if (be[1]) begin
      res[15:8] = wr[15:8];
    end
    return res;
  endfunction

  function automatic logic isMapped(input logic [31:0] a);
    return a == `ADDR_RECEIVE_BYTE || a == `ADDR_TRANSMIT_BYTE || a == `ADDR_READ_LENGTH ||
           a == `ADDR_READ_PROGRESS || a == `ADDR_TARGET_ADDRESS || a == `ADDR_CLOCK_DIVIDER ||
           a == `ADDR_MASTER_STATUS;
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] receiveByte_q;
  logic [7:0] transmitByte_q;
  logic [8:0] readLength_q;
  logic [9:0] rxCount_q;
  logic [7:0] targetAddress_q;
  logic [15:0] clockDivider_q;
  logic nack_q;
  engine_state_e state_q;
  byte_kind_e kind_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic lastByte_q;
  logic sclOeN_q;
  logic sdaOeN_q;
  logic waitReq_q;
  logic [31:0] readData_q;
  logic [1:0] response_q;
  logic accept;
  logic busWrite;
  logic startReq;
  logic [9:0] rxTotal;
  logic [7:0] newShift;
  logic tick;

  scl_timing_if tim ();

  scl_timer u_timer (
    .clock(clock),
    .srst(srst),
    .tim(tim.timer)
  );

  assign tim.divValue = clockDivider_q;
  assign tim.run = state_q != ST_IDLE;
  assign tim.sclHigh = sclOeN_q;
  assign tick = tim.tick;

  assign accept = (avsRead || avsWrite) && !waitReq_q;
  assign busWrite = avsWrite && !waitReq_q;
  assign startReq = busWrite && avsByteEnable[0] && avsAddress == `ADDR_TARGET_ADDRESS && state_q == ST_IDLE;
  assign rxTotal = {1'b0, readLength_q} + 10'h001;
  assign newShift = {shift_q[6:0], sdaIn};

  // ************************************************************
  // Avalon answer: one wait cycle, then waitrequest low one cycle
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      waitReq_q <= 1'b1;
      readData_q <= 32'h00000000;
      response_q <= `RESP_OKAY;
    end else begin
      waitReq_q <= !((avsRead || avsWrite) && waitReq_q);
      if ((avsRead || avsWrite) && waitReq_q) begin
        response_q <= isMapped(avsAddress) ? `RESP_OKAY : `RESP_SLVERR;
        case (avsAddress)
          `ADDR_RECEIVE_BYTE: readData_q <= {24'h000000, receiveByte_q};
          `ADDR_TRANSMIT_BYTE: readData_q <= {24'h000000, transmitByte_q};
          `ADDR_READ_LENGTH: readData_q <= {23'h000000, readLength_q};
          `ADDR_READ_PROGRESS: readData_q <= {24'h000000, rxCount_q[7:0]};
          `ADDR_TARGET_ADDRESS: readData_q <= {24'h000000, targetAddress_q};
          `ADDR_CLOCK_DIVIDER: readData_q <= {16'h0000, clockDivider_q};
          `ADDR_MASTER_STATUS: readData_q <= {30'h00000000, nack_q, state_q != ST_IDLE};
          default: readData_q <= 32'h00000000;
        endcase
      end
    end
  end

  // ************************************************************
  // Software written registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      transmitByte_q <= `RST_BYTE;
      readLength_q <= `RST_READ_LENGTH;
      targetAddress_q <= `RST_BYTE;
      clockDivider_q <= `RST_CLOCK_DIVIDER;
    end else if (busWrite) begin
      case (avsAddress)
        `ADDR_TRANSMIT_BYTE: transmitByte_q <= 8'(mergeLanes({8'h00, transmitByte_q}, avsWriteData, avsByteEnable));
        `ADDR_READ_LENGTH: readLength_q <= 9'(mergeLanes({7'h00, readLength_q}, avsWriteData, avsByteEnable));
        `ADDR_TARGET_ADDRESS: targetAddress_q <= 8'(mergeLanes({8'h00, targetAddress_q}, avsWriteData, avsByteEnable));
        `ADDR_CLOCK_DIVIDER: clockDivider_q <= mergeLanes(clockDivider_q, avsWriteData, avsByteEnable);
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Received data and progress count
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      receiveByte_q <= `RST_BYTE;
      rxCount_q <= 10'h000;
    end else if (startReq) begin
      rxCount_q <= 10'h000;
    end else if (state_q == ST_BIT_HIGH && tick && kind_q == KIND_RECEIVE && bitCnt_q == `LAST_DATA_BIT) begin
      receiveByte_q <= newShift;
      rxCount_q <= rxCount_q + 10'h001;
    end
  end

  // ************************************************************
  // Byte engine
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      kind_q <= KIND_ADDRESS;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      lastByte_q <= 1'b0;
      nack_q <= 1'b0;
      sclOeN_q <= 1'b1;
      sdaOeN_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            shift_q <= avsWriteData[7:0];
            kind_q <= KIND_ADDRESS;
            nack_q <= 1'b0;
            sdaOeN_q <= 1'b0;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            sclOeN_q <= 1'b0;
            sdaOeN_q <= shift_q[7];
            bitCnt_q <= 4'h0;
            state_q <= ST_BIT_LOW;
          end
        end
        ST_BIT_LOW: begin
          if (tick) begin
            sclOeN_q <= 1'b1;
            state_q <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH: begin
          if (tick) begin
            sclOeN_q <= 1'b0;
            state_q <= ST_BIT_LOW;
            if (bitCnt_q != `ACK_BIT) begin
              shift_q <= newShift;
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q != `LAST_DATA_BIT) begin
                sdaOeN_q <= (kind_q == KIND_RECEIVE) ? 1'b1 : newShift[7];
              end else if (kind_q == KIND_RECEIVE) begin
                lastByte_q <= rxCount_q + 10'h001 >= rxTotal;
                sdaOeN_q <= rxCount_q + 10'h001 >= rxTotal;
              end else begin
                sdaOeN_q <= 1'b1;
              end
            end else begin
              bitCnt_q <= 4'h0;
              if (kind_q != KIND_RECEIVE && sdaIn) begin
                nack_q <= 1'b1;
                sdaOeN_q <= 1'b0;
                state_q <= ST_STOP_LOW;
              end else if (kind_q == KIND_ADDRESS && targetAddress_q[`ADDR_DIR_BIT]) begin
                kind_q <= KIND_RECEIVE;
                sdaOeN_q <= 1'b1;
              end else if (kind_q == KIND_ADDRESS) begin
                kind_q <= KIND_TRANSMIT;
                shift_q <= transmitByte_q;
                sdaOeN_q <= transmitByte_q[7];
              end else if (kind_q == KIND_RECEIVE && !lastByte_q) begin
                sdaOeN_q <= 1'b1;
              end else begin
                sdaOeN_q <= 1'b0;
                state_q <= ST_STOP_LOW;
              end
            end
          end
        end
        ST_STOP_LOW: begin
          if (tick) begin
            sclOeN_q <= 1'b1;
            state_q <= ST_STOP_HIGH;
          end
        end
        ST_STOP_HIGH: begin
          if (tick) begin
            sdaOeN_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Output flops
  // ************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  assign sclOeN = sclOeN_q;
  assign sdaOeN = sdaOeN_q;
  assign avsWaitRequest = waitReq_q;
  assign avsReadData = readData_q;
  assign avsResponse = response_q;

  logic unusedScl;
  assign unusedScl = sclIn;

endmodule // i2c_master_data_count_regs
`default_nettype wire

// ===== tb/i2c_slave_model.sv
/*
  Behavioural I2C slave: acks its address, takes written bytes, sends a count pattern on reads.
  Assumes the bench resolves the open-drain wires with pull-ups.
*/
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model #(
  parameter logic [6:0] SLV = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  output logic slvOeN
);
  logic [7:0] sh, tx, dat, got;
  logic act, first, rd, ack;
  int bitN, sent;
  initial begin
    slvOeN = 1'b1;
    act = 1'b0;
    got = 8'h00;
    sent = 0;
  end
  // *****
  // Start and stop detection
  // *****
  // Settle first: SDA may move in the same step as SCL falls
  always @(negedge sda) begin
    #1;
    if (scl && !sda) begin
      act = 1'b1;
      first = 1'b1;
      bitN = 0;
      sent = 0;
      dat = 8'hA0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl && sda) act = 1'b0;
  end
  // *****
  // Bit handling
  // *****
  always @(posedge scl) if (act) begin
    if (bitN < 8) sh = {sh[6:0], sda};
    else if (rd && !first && sda) act = 1'b0;
    bitN++;
  end
  always @(negedge scl) if (act) begin
    if (bitN == 8) begin
      if (first) begin
        rd = sh[0];
        ack = (sh[7:1] == SLV);
      end else if (!rd) got = sh;
      slvOeN = !(ack && (first || !rd));
    end else if (bitN == 9) begin
      bitN = 0;
      first = 1'b0;
      tx = dat;
      if (rd && ack) begin
        dat++;
        sent++;
      end
      slvOeN = !(rd && ack) | tx[7];
    end else slvOeN = (rd && ack && !first) ? tx[7 - bitN] : 1'b1;
  end else slvOeN = 1'b1;
endmodule // i2c_slave_model
`default_nettype wire

// ===== tb/i2c_master_data_count_regs_chk.sv
/*
  Checker for the I2C master register block, bound to its top ports.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_consts.svh"
module i2c_master_data_count_regs_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic [1:0] avsResponse,
  input wire logic avsWaitRequest,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOeN,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] divLo_q;
  logic [15:0] lowCnt_q;
  logic done;
  assign done = avsRead && !avsWaitRequest;
  always_ff @(posedge clock) begin
    if (srst) divLo_q <= 8'h1F;
    else if (avsWrite && !avsWaitRequest && avsAddress == `ADDR_CLOCK_DIVIDER && avsByteEnable[0])
      divLo_q <= avsWriteData[7:0];
  end
  always_ff @(posedge clock) begin
    if (srst || sclOeN) lowCnt_q <= 16'h0000;
    else lowCnt_q <= lowCnt_q + 16'h0001;
  end
  // *****
  // Properties
  // *****
  property p_wait_one; (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
  property p_wait_pulse; !avsWaitRequest |=> avsWaitRequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_wait_idle; !(avsRead || avsWrite) && avsWaitRequest |=> avsWaitRequest; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  property p_slverr; done && !(avsAddress inside {`ADDR_RECEIVE_BYTE, `ADDR_TRANSMIT_BYTE, `ADDR_READ_LENGTH,
    `ADDR_READ_PROGRESS, `ADDR_TARGET_ADDRESS, `ADDR_CLOCK_DIVIDER, `ADDR_MASTER_STATUS})
    |-> avsResponse == `RESP_SLVERR && avsReadData == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  property p_prog_bits; done && avsAddress == `ADDR_READ_PROGRESS |-> avsReadData[31:8] == 24'h0; endproperty
  a_prog_bits: assert property (p_prog_bits) else $error("progress wider than a byte");
  property p_len_bits; done && avsAddress == `ADDR_READ_LENGTH |-> avsReadData[31:9] == 23'h0; endproperty
  a_len_bits: assert property (p_len_bits) else $error("reserved length bits set");
  property p_scl_low; $rose(sclOeN) |-> lowCnt_q == {8'h00, divLo_q} + 16'h0002; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low half length wrong");
  property p_od_zero; sclOut == 1'b0 && sdaOut == 1'b0; endproperty
  a_od_zero: assert property (p_od_zero) else $error("open-drain value not zero");
  property p_rst_idle; disable iff (1'b0) srst |=> avsWaitRequest && sclOeN && sdaOeN; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
endmodule // i2c_master_data_count_regs_chk
bind i2c_master_data_count_regs i2c_master_data_count_regs_chk u_chk (.clock, .srst, .avsAddress, .avsRead,
  .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsResponse, .avsWaitRequest, .sclIn, .sclOut,
  .sclOeN, .sdaIn, .sdaOut, .sdaOeN);
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench for the I2C master register block with a slave model.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_consts.svh"
module testbench;
  localparam logic [6:0] SLV = 7'h2A;
  logic clock, srst, avsRead, avsWrite, sclOut, sclOeN, sdaOut, sdaOeN, slvOeN, avsWaitRequest;
  logic [31:0] avsAddress, avsWriteData, avsReadData, q;
  logic [3:0] avsByteEnable;
  logic [1:0] avsResponse;
  logic [1:0] resp;
  logic [32:0] expQ [$];
  logic [32:0] e;
  logic [15:0] seed;
  logic [8:0] lens [3];
  logic [31:0] regA [7] = '{`ADDR_RECEIVE_BYTE, `ADDR_TRANSMIT_BYTE, `ADDR_READ_LENGTH, `ADDR_READ_PROGRESS,
    `ADDR_TARGET_ADDRESS, `ADDR_CLOCK_DIVIDER, 32'hFFFF0800};
  logic [31:0] regR [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F1F, 32'h0};
  int fails, tests_run, i;
  wire logic sclIn = sclOeN;
  wire logic sdaIn = sdaOeN & slvOeN;
  i2c_master_data_count_regs u_dut (.clock, .srst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsResponse, .avsWaitRequest, .sclIn, .sclOut, .sclOeN, .sdaIn, .sdaOut,
    .sdaOeN);
  i2c_slave_model #(.SLV(SLV)) u_slave (.scl(sclIn), .sda(sdaIn), .slvOeN(slvOeN));
  always #5 clock = ~clock;
  // *****
  // Helpers
  // *****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] x);
    int n;
    @(posedge clock);
    if (!w) expQ.push_back(x);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      conclude();
    end
    q = avsReadData;
    resp = avsResponse;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic idle();
    int n;
    repeat (4) @(posedge clock);
    n = 0;
    do begin
      bus(1'b0, `ADDR_MASTER_STATUS, 32'h0, 33'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 9000);
    if (n >= 9000) begin
      fails++;
      conclude();
    end
  endtask
  // *****
  // Read watcher
  // *****
  always @(posedge clock) if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
    e = expQ.pop_front();
    if (e[32]) cmp(avsReadData, e[31:0]);
  end
  // *****
  // Main sequence
  // *****
  initial begin
    clock = 1'b0;
    srst = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    avsByteEnable = 4'h3;
    seed = 16'hA981;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    for (i = 0; i < 7; i++) bus(1'b0, regA[i], 32'h0, {1'b1, regR[i]});
    cmp({30'h0, resp}, {30'h0, `RESP_SLVERR});
    bus(1'b1, `ADDR_CLOCK_DIVIDER, 32'h0102, 33'h0);
    bus(1'b0, `ADDR_CLOCK_DIVIDER, 32'h0, {1'b1, 32'h0102});
    cmp({30'h0, resp}, {30'h0, `RESP_OKAY});
    bus(1'b1, `ADDR_READ_LENGTH, 32'hFFFF, 33'h0);
    bus(1'b0, `ADDR_READ_LENGTH, 32'h0, {1'b1, 32'h01FF});
    bus(1'b1, `ADDR_READ_PROGRESS, 32'h55, 33'h0);
    bus(1'b0, `ADDR_READ_PROGRESS, 32'h0, {1'b1, 32'h0});
    seed = lfsr(seed);
    bus(1'b1, `ADDR_TRANSMIT_BYTE, {24'h0, seed[7:0]}, 33'h0);
    bus(1'b0, `ADDR_TRANSMIT_BYTE, 32'h0, {1'b1, 24'h0, seed[7:0]});
    bus(1'b1, `ADDR_TARGET_ADDRESS, {24'h0, SLV, 1'b0}, 33'h0);
    idle();
    cmp({24'h0, u_slave.got}, {24'h0, seed[7:0]});
    bus(1'b0, `ADDR_MASTER_STATUS, 32'h0, {1'b1, 32'h0});
    bus(1'b1, `ADDR_TARGET_ADDRESS, {24'h0, SLV ^ 7'h01, 1'b0}, 33'h0);
    idle();
    bus(1'b0, `ADDR_MASTER_STATUS, 32'h0, {1'b1, 32'h2});
    seed = lfsr(seed);
    lens = '{9'h000, {6'h00, seed[2:0]}, 9'h100};
    for (i = 0; i < 3; i++) begin
      bus(1'b1, `ADDR_READ_LENGTH, {23'h0, lens[i]}, 33'h0);
      bus(1'b1, `ADDR_TARGET_ADDRESS, {24'h0, SLV, 1'b1}, 33'h0);
      idle();
      bus(1'b0, `ADDR_READ_PROGRESS, 32'h0, {1'b1, 24'h0, lens[i][7:0] + 8'h01});
      bus(1'b0, `ADDR_RECEIVE_BYTE, 32'h0, {1'b1, 24'h0, lens[i][7:0] + 8'hA0});
      cmp(32'(u_slave.sent), {23'h0, lens[i]} + 32'h1);
    end
    conclude();
  end
endmodule // testbench
`default_nettype wire
